// file: design/aoms_cfg.svh
// constants of the operating-mode sequencer
`ifndef AOMS_CFG_SVH
`define AOMS_CFG_SVH
// register offsets
`define AOMS_OFF_MODE 4'h0
`define AOMS_OFF_CTRL 4'h1
`define AOMS_OFF_STAT 4'h2
`define AOMS_OFF_IRQ_ST 4'h3
`define AOMS_OFF_IRQ_MSK 4'h4
`define AOMS_OFF_RES_LO 4'h5
`define AOMS_OFF_RES_HI 4'h6
`define AOMS_OFF_OFS 4'h7
`define AOMS_OFF_GAIN 4'h8
// mode register fields
`define AOMS_MODE_MSB 15
`define AOMS_MODE_LSB 13
`define AOMS_CH_MSB 1
`define AOMS_CH_LSB 0
`define AOMS_MODE_RST 16'h01b0
// timing
`define AOMS_CONV_CYC 16'd1000
`define AOMS_SETTLE_CYC 16'd3000
`define AOMS_CAL_CYC 16'd4000
`endif

// file: design/aoms_pkg.sv
// types of the operating-mode sequencer
package aoms_pkg;
  typedef enum logic [2:0] {
    AOMS_IDLE = 3'b000,
    AOMS_CONT = 3'b001,
    AOMS_SINGLE = 3'b010,
    AOMS_STBY = 3'b011,
    AOMS_ZS_SELF = 3'b100,
    AOMS_FS_SELF = 3'b101,
    AOMS_ZS_SYS = 3'b110,
    AOMS_FS_SYS = 3'b111
  } aoms_mode_type;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } aoms_bus_req_type;

  typedef struct packed {
    logic ofs_we;
    logic gain_we;
    logic [1:0] ch;
    logic [23:0] value;
  } aoms_cal_upd_type;
endpackage

// file: design/aoms_sync.sv
// two-flop synchroniser for a pin level
`timescale 1ns/1ps
`default_nettype none
module aoms_sync
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // level
  input wire logic i_async,
  output logic o_sync
);
  logic meta_q;

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      meta_q <= 1'b0;
      o_sync <= 1'b0;
    end
    else
    begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule
`default_nettype wire

// file: design/aoms_timer.sv
// down counter that pulses when a started interval elapses
`timescale 1ns/1ps
`default_nettype none
module aoms_timer
#(
  parameter int WIDTH = 16
)
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // control
  input wire logic i_start,
  input wire logic i_abort,
  input wire logic [WIDTH-1:0] i_len,
  output logic o_busy,
  output logic o_done
);
  logic [WIDTH-1:0] cnt_q;

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cnt_q <= '0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end
    else
    begin
      o_done <= 1'b0;
      if (i_start)
      begin
        cnt_q <= i_len;
        o_busy <= 1'b1;
      end
      else if (i_abort)
        o_busy <= 1'b0;
      else if (o_busy)
      begin
        if (cnt_q <= WIDTH'(1))
        begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end
        else
          cnt_q <= cnt_q - WIDTH'(1);
      end
    end
  end
endmodule
`default_nettype wire

// file: design/aoms_seq.sv
// operating-mode sequencer of a bridge sigma-delta converter
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "aoms_cfg.svh"
module aoms_seq
#(
  parameter logic [15:0] CONV_CYC = `AOMS_CONV_CYC,
  parameter logic [15:0] SETTLE_CYC = `AOMS_SETTLE_CYC,
  parameter logic [15:0] CAL_CYC = `AOMS_CAL_CYC
)
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // register port
  input wire aoms_pkg::aoms_bus_req_type i_bus,
  output logic [15:0] o_rdata,
  // pins
  input wire logic i_idle_hold,
  input wire logic i_standby,
  // converter datapath
  input wire logic [23:0] i_sample,
  output logic o_mod_reset,
  output logic o_power_down,
  output logic o_ready_n,
  output aoms_pkg::aoms_cal_upd_type o_cal_upd,
  output logic o_irq
);
  import aoms_pkg::*;

  // ==========================================
  // pin synchronisers
  logic hold_s;
  logic stby_s;

  aoms_sync u_sync_hold
  (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_async(i_idle_hold),
    .o_sync(hold_s)
  );

  aoms_sync u_sync_stby
  (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_async(i_standby),
    .o_sync(stby_s)
  );

  // ==========================================
  // registers
  logic [15:0] mode_reg_q;
  logic [23:0] result_q;
  logic [23:0] ofs_q [4];
  logic [23:0] gain_q [4];
  logic [2:0] irq_st_q;
  logic [2:0] irq_msk_q;
  logic ready_n_q;
  logic read_lo_q;
  logic tmr_busy;
  logic tmr_done;
  logic tmr_start;
  logic tmr_abort;
  logic [15:0] tmr_len;
  logic conv_done;
  logic cal_done;
  aoms_mode_type mode;
  logic [1:0] ch;
  logic halted;
  logic mode_wr;
  logic is_cal;

  assign mode = aoms_mode_type'(mode_reg_q[`AOMS_MODE_MSB:`AOMS_MODE_LSB]);
  assign ch = mode_reg_q[`AOMS_CH_MSB:`AOMS_CH_LSB];
  assign is_cal = mode_reg_q[`AOMS_MODE_MSB];
  assign halted = hold_s || stby_s;
  assign mode_wr = i_bus.wr && (i_bus.addr == `AOMS_OFF_MODE);

  // ==========================================
  // operation timer
  always_comb
  begin
    tmr_start = 1'b0;
    tmr_len = CONV_CYC;
    tmr_abort = mode_wr || halted;
    if (!halted && !tmr_busy && !mode_wr && !tmr_done)
    begin
      unique case (mode)
        AOMS_CONT:
        begin
          tmr_start = 1'b1;
          tmr_len = CONV_CYC;
        end
        AOMS_SINGLE:
        begin
          tmr_start = 1'b1;
          tmr_len = SETTLE_CYC;
        end
        AOMS_ZS_SELF, AOMS_FS_SELF, AOMS_ZS_SYS, AOMS_FS_SYS:
        begin
          tmr_start = 1'b1;
          tmr_len = CAL_CYC;
        end
        AOMS_IDLE, AOMS_STBY:
          tmr_start = 1'b0;
      endcase
    end
  end

  aoms_timer #(.WIDTH(16)) u_timer
  (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_start(tmr_start),
    .i_abort(tmr_abort),
    .i_len(tmr_len),
    .o_busy(tmr_busy),
    .o_done(tmr_done)
  );

  assign conv_done = tmr_done && !halted && (mode == AOMS_CONT || mode == AOMS_SINGLE);
  assign cal_done = tmr_done && !halted && is_cal;

  // ==========================================
  // mode register
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      mode_reg_q <= `AOMS_MODE_RST;
    else if (mode_wr)
      mode_reg_q <= i_bus.wdata;
    else if (cal_done || (conv_done && mode == AOMS_SINGLE))
      mode_reg_q[`AOMS_MODE_MSB:`AOMS_MODE_LSB] <= AOMS_IDLE;
  end

  // ==========================================
  // result and calibration registers
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      result_q <= '0;
    else if (conv_done)
      result_q <= i_sample;
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      o_cal_upd <= '0;
    else
    begin
      o_cal_upd <= '0;
      o_cal_upd.ch <= ch;
      o_cal_upd.value <= i_sample;
      if (cal_done)
      begin
        o_cal_upd.ofs_we <= (mode != AOMS_FS_SYS);
        o_cal_upd.gain_we <= (mode == AOMS_FS_SELF) || (mode == AOMS_FS_SYS);
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      for (int i = 0; i < 4; i++)
        ofs_q[i] <= '0;
    end
    else if (o_cal_upd.ofs_we)
      ofs_q[o_cal_upd.ch] <= o_cal_upd.value;
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      for (int i = 0; i < 4; i++)
        gain_q[i] <= '0;
    end
    else if (o_cal_upd.gain_we)
      gain_q[o_cal_upd.ch] <= o_cal_upd.value;
  end

  // ==========================================
  // ready flag
  // a calibration write wins over a conversion ending in the same cycle
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      ready_n_q <= 1'b1;
    else if (mode_wr && i_bus.wdata[`AOMS_MODE_MSB])
      ready_n_q <= 1'b1;
    else if (conv_done)
      ready_n_q <= 1'b0;
    else if (cal_done)
      ready_n_q <= 1'b0;
    else if (i_bus.rd && i_bus.addr == `AOMS_OFF_RES_HI && read_lo_q)
      ready_n_q <= 1'b1;
  end

  // low half of the result read since the last update
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      read_lo_q <= 1'b0;
    else if (conv_done)
      read_lo_q <= 1'b0;
    else if (i_bus.rd && i_bus.addr == `AOMS_OFF_RES_LO)
      read_lo_q <= 1'b1;
  end

  // ==========================================
  // interrupts: conversion done, calibration done, halted
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      irq_st_q <= '0;
      irq_msk_q <= '0;
    end
    else
    begin
      if (i_bus.wr && i_bus.addr == `AOMS_OFF_IRQ_MSK)
        irq_msk_q <= i_bus.wdata[2:0];
      irq_st_q <= (irq_st_q & ~((i_bus.wr && i_bus.addr == `AOMS_OFF_IRQ_ST) ? i_bus.wdata[2:0] : 3'h0))
                  | {halted, cal_done, conv_done};
    end
  end

  // ==========================================
  // outputs and read port
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      o_mod_reset <= 1'b1;
    else
      o_mod_reset <= hold_s || mode == AOMS_IDLE || mode == AOMS_STBY || stby_s;
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      o_power_down <= 1'b0;
    else
      o_power_down <= stby_s || mode == AOMS_STBY;
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      o_irq <= 1'b0;
    else
      o_irq <= |(irq_st_q & irq_msk_q);
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      o_ready_n <= 1'b1;
    else
      o_ready_n <= ready_n_q;
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      o_rdata <= '0;
    else if (i_bus.rd)
    begin
      unique case (i_bus.addr)
        `AOMS_OFF_MODE: o_rdata <= mode_reg_q;
        `AOMS_OFF_CTRL: o_rdata <= {14'h0, stby_s, hold_s};
        `AOMS_OFF_STAT: o_rdata <= {12'h0, tmr_busy, o_power_down, o_mod_reset, ready_n_q};
        `AOMS_OFF_IRQ_ST: o_rdata <= {13'h0, irq_st_q};
        `AOMS_OFF_IRQ_MSK: o_rdata <= {13'h0, irq_msk_q};
        `AOMS_OFF_RES_LO: o_rdata <= result_q[15:0];
        `AOMS_OFF_RES_HI: o_rdata <= {8'h0, result_q[23:16]};
        `AOMS_OFF_OFS: o_rdata <= ofs_q[ch][15:0];
        `AOMS_OFF_GAIN: o_rdata <= gain_q[ch][15:0];
        default: o_rdata <= 16'h0000;
      endcase
    end
    else
      o_rdata <= 16'h0000;
  end
endmodule
`default_nettype wire

// file: verification/aoms_seq_sva.sv
// assertions of the operating-mode sequencer
`timescale 1ns/1ps
`default_nettype none
module aoms_seq_sva
#(
  parameter logic [15:0] CONV_CYC = 16'h0004,
  parameter logic [15:0] SETTLE_CYC = 16'h0006,
  parameter logic [15:0] CAL_CYC = 16'h0008
)
(
  // clock, reset, register port, pins
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire aoms_pkg::aoms_bus_req_type i_bus,
  input wire logic [15:0] o_rdata,
  input wire logic i_idle_hold,
  input wire logic i_standby,
  // datapath
  input wire logic [23:0] i_sample,
  input wire logic o_mod_reset,
  input wire logic o_power_down,
  input wire logic o_ready_n,
  input wire aoms_pkg::aoms_cal_upd_type o_cal_upd,
  input wire logic o_irq
);
  import aoms_pkg::*;
  wire mwr = i_bus.wr && i_bus.addr == 4'h0;
  wire pins = i_idle_hold || i_standby;
  wire cal_we = o_cal_upd.ofs_we || o_cal_upd.gain_we;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  // ==========
  // mode and pins
  property p_idle_mode; mwr && i_bus.wdata[15:13] == 3'b000 |-> ##[1:2] o_mod_reset; endproperty
  a_idle_mode: assert property (p_idle_mode) else $error("idle write without reset");
  property p_hold_pin; i_idle_hold [*4] |-> o_mod_reset; endproperty
  a_hold_pin: assert property (p_hold_pin) else $error("idle hold ignored");
  property p_stby_pin; i_standby [*4] |-> o_power_down; endproperty
  a_stby_pin: assert property (p_stby_pin) else $error("standby pin ignored");
  property p_stby_mode; mwr && !i_idle_hold && i_bus.wdata[15:13] == 3'b011 |-> ##[1:2] o_power_down; endproperty
  a_stby_mode: assert property (p_stby_mode) else $error("standby mode ignored");
  property p_single_wait; mwr && !pins && i_bus.wdata[15:13] == 3'b010 |=> (!$fell(o_ready_n)) [*5]; endproperty
  a_single_wait: assert property (p_single_wait) else $error("result before settling");
  // ==========
  // calibration
  property p_cal_rdy; mwr && !pins && i_bus.wdata[15] |-> ##[1:2] o_ready_n; endproperty
  a_cal_rdy: assert property (p_cal_rdy) else $error("ready not high at start");
  property p_cal_end; cal_we |-> ##[0:3] !o_ready_n; endproperty
  a_cal_end: assert property (p_cal_end) else $error("ready not low at end");
  property p_cal_idle; cal_we |-> ##[0:3] o_mod_reset; endproperty
  a_cal_idle: assert property (p_cal_idle) else $error("no idle after calibration");
  property p_abandon; mwr && i_bus.wdata == 16'h0000 |-> ##2 (!cal_we) [*6]; endproperty
  a_abandon: assert property (p_abandon) else $error("abandoned calibration finished");
  c_result: cover property ($fell(o_ready_n));
  c_cal: cover property (cal_we);
  c_irq: cover property ($rose(o_irq));
endmodule
bind aoms_seq aoms_seq_sva #(.CONV_CYC(CONV_CYC), .SETTLE_CYC(SETTLE_CYC), .CAL_CYC(CAL_CYC)) u_sva (
  .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_bus(i_bus), .o_rdata(o_rdata),
  .i_idle_hold(i_idle_hold), .i_standby(i_standby), .i_sample(i_sample), .o_mod_reset(o_mod_reset),
  .o_power_down(o_power_down), .o_ready_n(o_ready_n), .o_cal_upd(o_cal_upd), .o_irq(o_irq));
`default_nettype wire

// file: verification/aoms_host.sv
// host model driving the register port
`timescale 1ns/1ps
`default_nettype none
module aoms_host
(
  // clock
  input wire logic i_clk_sys,
  // register port
  output var aoms_pkg::aoms_bus_req_type o_bus,
  input wire logic [15:0] i_rdata
);
  import aoms_pkg::*;
  initial o_bus = '0;
  // strobe stands one cycle, released at the edge that takes it
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk_sys);
    o_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk_sys);
    o_bus <= '0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge i_clk_sys);
    o_bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk_sys);
    o_bus <= '0;
    #1 d = i_rdata;
  endtask
endmodule
`default_nettype wire

// file: verification/aoms_seq_tb.sv
// self-checking bench of the operating-mode sequencer
`timescale 1ns/1ps
`default_nettype none
module aoms_seq_tb;
  import aoms_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_resetn = 1'b0;
  logic i_idle_hold = 1'b0;
  logic i_standby = 1'b0;
  logic [23:0] i_sample = 24'h123456;
  aoms_bus_req_type bus;
  aoms_cal_upd_type cal_upd;
  logic [15:0] rdata;
  logic mod_reset, power_down, ready_n, irq, m0;
  int n_ofs = 0;
  int n_gain = 0;
  logic [1:0] seen_ch = 2'h0;
  int n_errors = 0;
  int num_checks = 0;
  always #5 i_clk_sys = ~i_clk_sys;
  aoms_host u_host (.i_clk_sys(i_clk_sys), .o_bus(bus), .i_rdata(rdata));
  aoms_seq #(.CONV_CYC(16'h0004), .SETTLE_CYC(16'h0006), .CAL_CYC(16'h0008)) dut (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_bus(bus), .o_rdata(rdata),
    .i_idle_hold(i_idle_hold), .i_standby(i_standby), .i_sample(i_sample), .o_mod_reset(mod_reset),
    .o_power_down(power_down), .o_ready_n(ready_n), .o_cal_upd(cal_upd), .o_irq(irq));
  always @(posedge i_clk_sys)
  begin
    if (cal_upd.ofs_we || cal_upd.gain_we)
      seen_ch <= cal_upd.ch;
    if (cal_upd.ofs_we)
      n_ofs <= n_ofs + 1;
    if (cal_upd.gain_we)
      n_gain <= n_gain + 1;
  end
  // ==========
  // helpers
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask
  task automatic rdc(input logic [3:0] a, input logic [15:0] exp, input string what);
    logic [15:0] d;
    u_host.rd(a, d);
    chk({8'h00, d}, {8'h00, exp}, what);
  endtask
  task automatic wait_rdy(input logic lvl, output int n);
    n = 0;
    while (ready_n !== lvl && n < 200)
    begin
      @(posedge i_clk_sys);
      #1 n++;
    end
    chk(24'(ready_n), 24'(lvl), "ready wait");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #100us;
    n_errors++;
    print_verdict();
  end
  // ==========
  // tests
  initial
  begin
    int n, o0, g0;
    logic [15:0] d;
    repeat (4) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    #1 chk(24'(mod_reset), 24'h1, "idle at reset");
    rdc(4'h0, 16'h01b0, "mode reset value");
    rdc(4'h9, 16'h0000, "unmapped read");
    $display("reset test done");
    u_host.wr(4'h0, 16'h4000);
    wait_rdy(1'b0, n);
    chk(24'(n >= 6), 24'h1, "single too early");
    rdc(4'h0, 16'h0000, "single mode cleared");
    rdc(4'h5, 16'h3456, "result low");
    chk(24'(ready_n), 24'h0, "ready before high part");
    rdc(4'h6, 16'h0012, "result high");
    wait_rdy(1'b1, n);
    chk(24'(n <= 2), 24'h1, "ready late after read");
    u_host.rd(4'h3, d);
    chk(24'(d[0]), 24'h1, "conversion event");
    u_host.wr(4'h4, 16'h0000);
    @(posedge i_clk_sys);
    #1 m0 = irq;
    u_host.wr(4'h4, 16'h0007);
    @(posedge i_clk_sys);
    #1 chk(24'(m0 ^ irq), 24'h1, "mask no effect");
    u_host.wr(4'h3, 16'h0007);
    @(posedge i_clk_sys);
    #1 chk(24'(irq), 24'h0, "irq after clear");
    $display("single test done");
    u_host.wr(4'h0, 16'h2000);
    wait_rdy(1'b0, n);
    @(posedge i_clk_sys);
    i_sample <= 24'h00beef;
    repeat (12) @(posedge i_clk_sys);
    rdc(4'h5, 16'hbeef, "continuous result");
    rdc(4'h0, 16'h2000, "continuous mode kept");
    for (int p = 0; p < 2; p++)
    begin
      @(posedge i_clk_sys);
      if (p == 0)
        i_idle_hold <= 1'b1;
      else
        i_standby <= 1'b1;
      repeat (4) @(posedge i_clk_sys);
      #1 chk(24'(p == 1 ? power_down : mod_reset), 24'h1, "pin level");
      rdc(4'h0, 16'h2000, "pin kept mode");
      rdc(4'h1, p == 1 ? 16'h0002 : 16'h0001, "pin state");
      @(posedge i_clk_sys);
      i_idle_hold <= 1'b0;
      i_standby <= 1'b0;
    end
    repeat (4) @(posedge i_clk_sys);
    $display("continuous and pin tests done");
    for (int c = 4; c < 8; c++)
    begin
      o0 = n_ofs;
      g0 = n_gain;
      u_host.wr(4'h0, {3'(c), 13'h0001});
      @(posedge i_clk_sys);
      #1 chk(24'(ready_n), 24'h1, "ready at cal start");
      rdc(4'h2, 16'h0009, "status at cal start");
      wait_rdy(1'b0, n);
      @(posedge i_clk_sys);
      #1 chk(24'(n_ofs - o0), 24'(c != 7), "cal offset writes");
      chk(24'(n_gain - g0), 24'(c[0]), "cal gain writes");
      chk(24'(seen_ch), 24'h1, "cal channel");
      rdc(c == 7 ? 4'h8 : 4'h7, 16'hbeef, "cal value");
      rdc(4'h0, 16'h0001, "cal back to idle");
    end
    $display("calibration test done");
    o0 = n_ofs;
    g0 = n_gain;
    u_host.wr(4'h0, 16'h8001);
    u_host.wr(4'h0, 16'h0000);
    repeat (20) @(posedge i_clk_sys);
    #1 chk(24'(n_ofs - o0 + n_gain - g0), 24'h0, "abandoned cal wrote");
    chk(24'(mod_reset), 24'h1, "idle mode reset");
    u_host.wr(4'h0, 16'h6000);
    @(posedge i_clk_sys);
    #1 chk(24'(power_down), 24'h1, "standby mode");
    $display("abandon and standby tests done");
    print_verdict();
  end
endmodule
`default_nettype wire
